// ### hw/emri_regs.svh
// Constants for the master request and PCI interrupt steering block
`ifndef EMRI_REGS_SVH
`define EMRI_REGS_SVH
`define EMRI_NUM_DED       4
`define EMRI_NUM_SHR       4
`define EMRI_NUM_SLOT      8
`define EMRI_MODE_ALL_IRQ  2'h0
`define EMRI_MODE_ONE_REQ  2'h1
`define EMRI_MODE_TWO_REQ  2'h2
`define EMRI_MODE_ALL_REQ  2'h3
`define EMRI_NO_SLOT       4'hf
`define EMRI_ROUTE_W       4
`define EMRI_ROUTE_OFF     4'h0
`define EMRI_IRQ_W         16
`define EMRI_IRQ_VALID     16'hfef8
`endif

// ### hw/emri_pkg.sv
// Types for the master request and PCI interrupt steering block
`default_nettype none
package emri_pkg;
  typedef enum logic [1:0]
  {
    EMRI_IDLE  = 2'b00,
    EMRI_OWNED = 2'b01,
    EMRI_DRAIN = 2'b10
  } emri_state_t;

  typedef struct packed
  {
    logic [3:0] slot;
    logic       busy;
  } emri_grant_t;
endpackage
`default_nettype wire

// ### hw/emri_pirq_steer.sv
// Steering of PCI interrupt inputs onto legacy interrupt lines
`default_nettype none
`include "emri_regs.svh"
module emri_pirq_steer
  import emri_pkg::*;
(
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [`EMRI_NUM_SHR-1:0]      irq_en_in,
  input  wire logic [`EMRI_NUM_SHR-1:0]      pirq_n_in,
  input  wire logic [4*`EMRI_ROUTE_W-1:0]    route_in,
  output logic      [`EMRI_IRQ_W-1:0]        irq_out
);
  logic [`EMRI_IRQ_W-1:0] irq_next;
  logic [`EMRI_IRQ_W-1:0] irq_reg;

  // ***************
  // Steering
  // ***************
  always_comb
  begin
    irq_next = '0;
    for (int i = 0; i < `EMRI_NUM_SHR; i++)
    begin
      if (irq_en_in[i] && !pirq_n_in[i]
          && route_in[i*`EMRI_ROUTE_W +: `EMRI_ROUTE_W] != `EMRI_ROUTE_OFF)
      begin
        irq_next[route_in[i*`EMRI_ROUTE_W +: `EMRI_ROUTE_W]] = 1'b1;
      end
    end
    // Only IRQ3-7 and IRQ9-15 may be shared
    irq_next = irq_next & `EMRI_IRQ_VALID;
  end

  // Registered so the controller sees a clean level, one cycle late
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_reg <= '0;
    else
      irq_reg <= irq_next;
  end

  assign irq_out = irq_reg;
endmodule
`default_nettype wire

// ### hw/emri_top.sv
// Master request arbitration front end with shared PCI interrupt pins
// Operation
// - Requests are synchronous and sampled on every rising edge.
// - The end of the owner's last cycle is taken from the command strobe.
// - Mode bits 1:0 choose request or interrupt use for the four shared pins.
// - A shared pin used as request follows the dedicated request protocol.
// - A shared pin used as interrupt goes to the interrupt controller.
// - PCI interrupt inputs are level sensitive and active low.
// - Per-input routing selects IRQ3-7 or IRQ9-15 for each interrupt.
`default_nettype none
`include "emri_regs.svh"
module emri_top
  import emri_pkg::*;
(
  input  wire logic                       MCLK_IN,
  input  wire logic                       RST_IN,
  input  wire logic [`EMRI_NUM_DED-1:0]   MREQ_N_IN,
  input  wire logic [`EMRI_NUM_SHR-1:0]   SHARED_N_IN,
  input  wire logic                       CMD_N_IN,
  input  wire logic [1:0]                 MODE_SEL_IN,
  input  wire logic [4*`EMRI_ROUTE_W-1:0] PCI_IRQ_ROUTING_CTRL_IN,
  output logic      [`EMRI_NUM_SLOT-1:0]  MACK_N_OUT,
  output logic      [`EMRI_IRQ_W-1:0]     IRQ_OUT
);
  emri_state_t                state_reg;
  emri_state_t                state_next;
  emri_grant_t                grant_reg;
  emri_grant_t                grant_next;
  logic [`EMRI_NUM_SLOT-1:0]  req_reg;
  logic [`EMRI_NUM_SLOT-1:0]  req_next;
  logic [`EMRI_NUM_SLOT-1:0]  mack_n_reg;
  logic [`EMRI_NUM_SLOT-1:0]  mack_n_next;
  logic                       cmd_seen_reg;
  logic                       cmd_seen_next;
  logic [`EMRI_NUM_SHR-1:0]   irq_en;
  logic [3:0]                 win_slot;
  logic                       win_valid;
  logic                       own_req;
  logic                       last_done;

  // Shared pin 0 maps to slot 7; mode picks how many act as requests
  function automatic logic [`EMRI_NUM_SHR-1:0] shared_is_irq(input logic [1:0] mode);
    unique case (mode)
      `EMRI_MODE_ALL_IRQ: shared_is_irq = 4'hf;
      `EMRI_MODE_ONE_REQ: shared_is_irq = 4'he;
      `EMRI_MODE_TWO_REQ: shared_is_irq = 4'hc;
      `EMRI_MODE_ALL_REQ: shared_is_irq = 4'h0;
    endcase
  endfunction

  // Lowest pending slot wins; the fixed order keeps this block small
  function automatic logic [3:0] pick_slot(input logic [`EMRI_NUM_SLOT-1:0] req);
    pick_slot = `EMRI_NO_SLOT;
    for (int i = `EMRI_NUM_SLOT - 1; i >= 0; i--)
      if (req[i])
        pick_slot = 4'(i);
  endfunction

  // ***************
  // Request sampling
  // ***************
  // mode bits select pin use
  assign irq_en = shared_is_irq(MODE_SEL_IN);

  always_comb
  begin
    req_next[`EMRI_NUM_DED-1:0] = ~MREQ_N_IN;
    for (int i = 0; i < `EMRI_NUM_SHR; i++)
      req_next[`EMRI_NUM_SLOT-1-i] = ~SHARED_N_IN[i] & ~irq_en[i];
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      req_reg <= '0;
    else
      req_reg <= req_next;
  end

  // ***************
  // Arbitration
  // ***************
  // Winner, owner and release terms shared by the three groups below
  assign win_slot  = pick_slot(req_reg);
  assign win_valid = (win_slot != `EMRI_NO_SLOT);
  assign own_req   = grant_reg.busy && req_reg[grant_reg.slot[2:0]];
  // last cycle ends with command strobe
  assign last_done = cmd_seen_reg && CMD_N_IN;

  // ***************
  // Ownership state
  // ***************
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      EMRI_IDLE:
      begin
        if (win_valid)
          state_next = EMRI_OWNED;
      end
      EMRI_OWNED:
      begin
        // Release starts once the owner drops its request
        if (!own_req)
          state_next = EMRI_DRAIN;
      end
      EMRI_DRAIN:
      begin
        if (last_done)
          state_next = EMRI_IDLE;
      end
      default:
      begin
        state_next = EMRI_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      state_reg <= EMRI_IDLE;
    else
      state_reg <= state_next;
  end

  // ***************
  // Command strobe watch
  // ***************
  // Strobes before the request drops are not counted, so earlier
  // cycles of the owner cannot end its tenure too soon
  always_comb
  begin
    cmd_seen_next = cmd_seen_reg;
    if (state_reg == EMRI_IDLE && win_valid)
      cmd_seen_next = 1'b0;
    else if (state_reg == EMRI_DRAIN && !CMD_N_IN)
      cmd_seen_next = 1'b1;
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      cmd_seen_reg <= 1'b0;
    else
      cmd_seen_reg <= cmd_seen_next;
  end

  // ***************
  // Grant outputs
  // ***************
  always_comb
  begin
    grant_next  = grant_reg;
    mack_n_next = mack_n_reg;
    unique case (state_reg)
      EMRI_IDLE:
      begin
        if (win_valid)
        begin
          grant_next.slot = win_slot;
          grant_next.busy = 1'b1;
          mack_n_next     = ~(`EMRI_NUM_SLOT'(1) << win_slot);
        end
      end
      EMRI_OWNED:
      begin
        // Grant stands through OWNED and DRAIN until last_done ends the owner's last cycle
        mack_n_next = mack_n_reg;
      end
      EMRI_DRAIN:
      begin
        if (last_done)
        begin
          mack_n_next = '1;
          grant_next  = '{slot: `EMRI_NO_SLOT, busy: 1'b0};
        end
      end
      default:
      begin
        mack_n_next = '1;
        grant_next  = '{slot: `EMRI_NO_SLOT, busy: 1'b0};
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      grant_reg  <= '{slot: `EMRI_NO_SLOT, busy: 1'b0};
      mack_n_reg <= '1;
    end
    else
    begin
      grant_reg  <= grant_next;
      mack_n_reg <= mack_n_next;
    end
  end

  assign MACK_N_OUT = mack_n_reg;

  // ***************
  // Interrupt path
  // ***************
  // interrupt pins to controller
  emri_pirq_steer u_steer
  (
    .clk_in    (MCLK_IN),
    .rst_in    (RST_IN),
    .irq_en_in (irq_en),
    .pirq_n_in (SHARED_N_IN),
    .route_in  (PCI_IRQ_ROUTING_CTRL_IN),
    .irq_out   (IRQ_OUT)
  );
endmodule
`default_nettype wire

// ### verif/emri_top_properties.sv
// Concurrent checks on the request and interrupt front end
`default_nettype none
`include "emri_regs.svh"
module emri_top_properties
(
  input wire logic        MCLK_IN,
  input wire logic        RST_IN,
  input wire logic [3:0]  MREQ_N_IN,
  input wire logic [3:0]  SHARED_N_IN,
  input wire logic        CMD_N_IN,
  input wire logic [1:0]  MODE_SEL_IN,
  input wire logic [15:0] PCI_IRQ_ROUTING_CTRL_IN,
  input wire logic [7:0]  MACK_N_OUT,
  input wire logic [15:0] IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  logic        idle;
  logic [15:0] vmask;
  logic [3:0]  r0;
  assign idle = &MACK_N_OUT;
  assign vmask = `EMRI_IRQ_VALID;
  assign r0 = PCI_IRQ_ROUTING_CTRL_IN[3:0];
  property p_one; $countones(~MACK_N_OUT) <= 1; endproperty
  a_one: assert property (p_one) else $error("two grants");
  property p_dgnt; idle && $past(idle) && !MREQ_N_IN[0] |-> ##2 MACK_N_OUT == 8'hfe; endproperty
  a_dgnt: assert property (p_dgnt) else $error("slot 0 grant");
  property p_sgnt; idle && $past(idle) && &MREQ_N_IN && MODE_SEL_IN == 2'h3
    && SHARED_N_IN == 4'h7 |-> ##2 MACK_N_OUT == 8'hef; endproperty
  a_sgnt: assert property (p_sgnt) else $error("shared grant");
  // Slot 0 grant ends only once the strobe went low and back high
  property p_rel; $rose(MACK_N_OUT[0]) |-> $past(CMD_N_IN, 1) && !$past(CMD_N_IN, 2); endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_irq; MODE_SEL_IN == 2'h0 && !SHARED_N_IN[0] && vmask[r0] |=> IRQ_OUT[$past(r0)];
  endproperty
  a_irq: assert property (p_irq) else $error("irq not routed");
  property p_map; (IRQ_OUT & ~vmask) == 16'h0; endproperty
  a_map: assert property (p_map) else $error("unmapped irq");
  property p_lvl; MODE_SEL_IN == 2'h0 && &SHARED_N_IN |=> IRQ_OUT == 16'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("irq while high");
  property p_mode; MODE_SEL_IN == 2'h3 |=> IRQ_OUT == 16'h0; endproperty
  a_mode: assert property (p_mode) else $error("irq in request mode");
endmodule
bind emri_top emri_top_properties u_props (.*);
`default_nettype wire

// ### verif/emri_mst_model.sv
// Behavioural slot master driving a request line and the strobe
`default_nettype none
module emri_mst_model
(
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [2:0] slot_in,
  input  wire logic [7:0] mack_n_in,
  output logic      [7:0] req_n_out,
  output logic            cmd_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Master
  // ****
  initial
  begin
    req_n_out = 8'hff;
    cmd_n_out = 1'b1;
    forever
    begin
      @(posedge go_in);
      @(negedge clk_in) req_n_out[slot_in] <= 1'b0;
      for (int i = 0; i < 40 && mack_n_in[slot_in]; i++)
        @(negedge clk_in);
      @(negedge clk_in) cmd_n_out <= 1'b0;
      @(negedge clk_in) req_n_out[slot_in] <= 1'b1;
      // no address or control outputs here, nothing left to float
      repeat (4) @(negedge clk_in);
      cmd_n_out <= 1'b1;
      repeat (2) @(negedge clk_in);
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the request and interrupt front end
`default_nettype none
`include "emri_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bench
  // ****
  logic        clk = 0, rst = 1, go = 0, cmd_n;
  logic [2:0]  slot = 0;
  logic [1:0]  mode = 2'h3;
  logic [3:0]  pin_n = 4'hf;
  logic [7:0]  req_n, mack_n;
  logic [15:0] route = 16'h0, irq;
  int          n_errors = 0, n_compared = 0;
  emri_top u_dut (.MCLK_IN(clk), .RST_IN(rst), .MREQ_N_IN(req_n[3:0]),
    .SHARED_N_IN({req_n[4], req_n[5], req_n[6], req_n[7]} & pin_n), .CMD_N_IN(cmd_n),
    .MODE_SEL_IN(mode), .PCI_IRQ_ROUTING_CTRL_IN(route), .MACK_N_OUT(mack_n), .IRQ_OUT(irq));
  emri_mst_model u_mst (.clk_in(clk), .go_in(go), .slot_in(slot), .mack_n_in(mack_n),
    .req_n_out(req_n), .cmd_n_out(cmd_n));
  initial forever #2.5 clk = ~clk;
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_irq(string n, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_gnt(string n, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // Bounded wait for a grant pattern
  task automatic wait_mack(logic [7:0] e);
    int i;
    for (i = 0; i < 40 && mack_n !== e; i++)
      cyc(1);
    if (i == 40)
    begin
      n_errors++;
      $display("[FAIL] mack exp %h got %h", e, mack_n);
      finish_test();
    end
  endtask
  task automatic req(int s);
    slot = 3'(s);
    go = 1;
    cyc(1);
    go = 0;
  endtask
  task automatic t_grant();
    for (int s = 0; s < 8; s++)
    begin
      req(s);
      wait_mack(~(8'h1 << s));
      chk_irq("irq", 16'h0, irq);
      wait_mack(8'hff);
      cyc(3);
    end
    $display("t_grant done");
  endtask
  // Pending shared slot waits while slot 0 owns the bus
  task automatic t_prio();
    req(0);
    wait_mack(8'hfe);
    pin_n = 4'h7;
    cyc(2);
    chk_gnt("busy", 8'hfe, mack_n);
    wait_mack(8'hef);
    rst = 1;
    cyc(2);
    pin_n = 4'hf;
    rst = 0;
    cyc(1);
    chk_gnt("reset", 8'hff, mack_n);
    $display("t_prio done");
  endtask
  task automatic t_irq();
    logic [15:0] v;
    v = `EMRI_IRQ_VALID;
    mode = 2'h0;
    for (int r = 0; r < 16; r++)
    begin
      route = 16'(r << (4 * (r % 4)));
      pin_n = ~(4'h1 << (r % 4));
      cyc(2);
      chk_irq("irq", v[r] ? 16'h1 << r : 16'h0, irq);
      chk_gnt("ign", 8'hff, mack_n);
      pin_n = 4'hf;
      cyc(2);
      chk_irq("idle", 16'h0, irq);
    end
    $display("t_irq done");
  endtask
  task automatic t_mode();
    mode = 2'h1;
    route = 16'h0090;
    pin_n = 4'hc;
    cyc(3);
    chk_irq("mix_irq", 16'h0200, irq);
    chk_gnt("mix_gnt", 8'h7f, mack_n);
    rst = 1;
    mode = 2'h2;
    route = 16'h0500;
    pin_n = 4'h9;
    cyc(2);
    rst = 0;
    cyc(3);
    chk_irq("two_irq", 16'h0020, irq);
    chk_gnt("two_gnt", 8'hbf, mack_n);
    rst = 1;
    cyc(1);
    $display("t_mode done");
  endtask
  initial
  begin
    cyc(12);
    rst = 0;
    t_grant();
    t_prio();
    t_irq();
    t_mode();
    finish_test();
  end
endmodule
`default_nettype wire
